// [verilog/i2s_port_defines.vh]
// Register offsets, field positions, reset values and bus response codes of the serial audio port
`ifndef I2S_PORT_DEFINES_VH
`define I2S_PORT_DEFINES_VH

// Register byte offsets
`define OFS_FUNC_SEL 8'h00
`define OFS_CFG 8'h04
`define OFS_DIV 8'h08
`define OFS_SLOT 8'h0C
`define OFS_MONO 8'h10
`define OFS_FIFO_TRIG 8'h14
`define OFS_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1C
`define OFS_FIFO_WR 8'h20
`define OFS_FIFO_RD 8'h24
`define OFS_FIFO_LVL 8'h28

// Function select values
`define FUNC_NONE 3'h0
`define FUNC_I2S 3'h5

// Configuration field positions
`define CFG_EN 0
`define CFG_MASTER 1
`define CFG_TX 2
`define CFG_RJUST 3
`define CFG_SCK_INV 4
`define CFG_WS_INV 5
`define CFG_TDM 6
`define CFG_PAIRS_LSB 8
`define CFG_WSIZE_LSB 12
`define CFG_FRAME_LSB 20

// Status bit positions
`define ST_TX_LOW 0
`define ST_RX_HIGH 1
`define ST_UNDERRUN 2
`define ST_OVERRUN 3

// Reset values
`define CFG_RESET 32'h0001_F000
`define DIV_RESET 8'h04
`define TRIG_RESET 8'h44

// Bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [verilog/sample_fifo_mem.v]
// Sample storage for the shared FIFO, read data registered
`timescale 1ns/1ps
`default_nettype none
module sample_fifo_mem #(
   parameter WIDTH = 32,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clocking
   input wire ref_clk,
   input wire ce,
   // Write side
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [WIDTH-1:0] wr_data,
   // Read side
   input wire [AW-1:0] rd_addr,
   output reg [WIDTH-1:0] rd_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];

   always @(posedge ref_clk) begin
      if (ce) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end
endmodule // sample_fifo_mem
`default_nettype wire

// [verilog/i2s_serial_port.v]
// I2S serial audio port with AXI4-Lite registers, shared FIFO and up to four channel pairs
`timescale 1ns/1ps
`default_nettype none
`include "i2s_port_defines.vh"
module i2s_serial_port #(
   parameter NUM_PAIRS = 4,
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   // Clock, reset, enable
   input wire ref_clk,
   input wire rst,
   input wire ce,
   // AXI4-Lite write
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // I2S pins
   input wire sck_in,
   output reg sck_out,
   output reg sck_oe,
   input wire ws_in,
   output reg ws_out,
   output reg ws_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   // Stream from microphone decimator
   input wire [31:0] mic_data,
   input wire mic_valid,
   output reg mic_ready,
   // DMA and interrupt
   output reg dma_tx_req,
   output reg dma_rx_req,
   output reg irq
);
   localparam PAIRS_W = 3;
   localparam [PAIRS_W-1:0] PAIRS_MAX = NUM_PAIRS[PAIRS_W-1:0];

   // Registers
   reg [2:0] func_reg;
   reg [31:0] cfg_reg;
   reg [7:0] div_reg;
   reg [31:0] slot_reg;
   reg [3:0] mono_reg;
   reg [7:0] trig_reg;
   reg [3:0] status_reg;
   reg [3:0] mask_reg;
   reg [3:0] ev;

   wire active = (func_reg == `FUNC_I2S) && cfg_reg[`CFG_EN];
   wire master = active && cfg_reg[`CFG_MASTER] && (NUM_PAIRS > 0);
   wire tx_mode = cfg_reg[`CFG_TX];
   wire rjust = cfg_reg[`CFG_RJUST];
   // size field holds size minus one, floor 4
   wire [4:0] wsize_m1 = (cfg_reg[`CFG_WSIZE_LSB +: 5] < 5'h03) ? 5'h03
                         : cfg_reg[`CFG_WSIZE_LSB +: 5];
   wire [7:0] frame_m1 = cfg_reg[`CFG_FRAME_LSB +: 8];
   // pair count clipped to the instance
   wire [PAIRS_W-1:0] pairs_req = cfg_reg[`CFG_PAIRS_LSB +: PAIRS_W];
   wire [PAIRS_W-1:0] pairs_used = (pairs_req > PAIRS_MAX) ? PAIRS_MAX : pairs_req;

   // Pin synchronisers
   reg [1:0] sck_s;
   reg [1:0] ws_s;
   reg [1:0] sda_s;
   reg sck_d;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sck_s <= 2'h0;
         ws_s <= 2'h0;
         sda_s <= 2'h0;
         sck_d <= 1'b0;
      end else if (ce) begin
         sck_s <= {sck_s[0], sck_in};
         ws_s <= {ws_s[0], ws_in};
         sda_s <= {sda_s[0], sda_in};
         sck_d <= sck_s[1];
      end
   end

   wire sck_pol = sck_s[1] ^ cfg_reg[`CFG_SCK_INV];
   wire sck_pol_d = sck_d ^ cfg_reg[`CFG_SCK_INV];
   wire ws_pol = ws_s[1] ^ cfg_reg[`CFG_WS_INV];

   // Master bit clock divider
   reg [7:0] div_cnt_reg;
   reg msck_reg;
   wire m_tick = master && (div_cnt_reg == div_reg);
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div_cnt_reg <= 8'h00;
         msck_reg <= 1'b0;
      end else if (ce) begin
         if (!master || m_tick) begin
            div_cnt_reg <= 8'h00;
         end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
         end
         if (!master) begin
            msck_reg <= 1'b0;
         end else if (m_tick) begin
            msck_reg <= ~msck_reg;
         end
      end
   end

   // bit edges from own clock or sampled pin
   wire fall_bit = master ? (m_tick && msck_reg) : (active && sck_pol_d && !sck_pol);
   wire rise_bit = master ? (m_tick && !msck_reg) : (active && !sck_pol_d && sck_pol);

   // Frame position, slave realigned on falling select edge
   reg [7:0] bitpos_reg;
   reg ws_prev_reg;
   wire ws_edge = !master && (ws_pol != ws_prev_reg);
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bitpos_reg <= 8'h00;
         ws_prev_reg <= 1'b0;
      end else if (ce) begin
         if (!active) begin
            bitpos_reg <= 8'h00;
         end else if (fall_bit) begin
            ws_prev_reg <= ws_pol;
            if ((ws_edge && !ws_pol) || bitpos_reg == frame_m1) begin
               bitpos_reg <= 8'h00;
            end else begin
               bitpos_reg <= bitpos_reg + 8'h01;
            end
         end
      end
   end

   // Slot arithmetic, channel length = word size
   function [7:0] slot_base;
      input [7:0] slot;
      input [4:0] wm1;
      begin
         slot_base = slot * ({3'h0, wm1} + 8'h01);
      end
   endfunction

   // slot of each channel from slot register
   reg ch_hit;
   reg [4:0] ch_bit;
   reg [7:0] base;
   reg [7:0] off;
   reg [1:0] p;
   integer i;
   always @* begin
      ch_hit = 1'b0;
      ch_bit = 5'h00;
      base = 8'h00;
      off = 8'h00;
      p = 2'h0;
      for (i = 0; i < 4; i = i + 1) begin
         p = i[1:0];
         base = slot_base(slot_reg[8*i +: 8], wsize_m1);
         if (!ch_hit && (i < pairs_used)) begin
            if (bitpos_reg >= base && bitpos_reg <= base + {3'h0, wsize_m1}) begin
               ch_hit = 1'b1;
               off = bitpos_reg - base;
               ch_bit = off[4:0];
            end else if (!mono_reg[p] && bitpos_reg > base + {3'h0, wsize_m1}
                         && bitpos_reg <= base + {wsize_m1, 1'b1}) begin
               ch_hit = 1'b1;
               off = bitpos_reg - base - {3'h0, wsize_m1} - 8'h01;
               ch_bit = off[4:0];
            end
         end
      end
   end
   wire slot_start = ch_hit && (ch_bit == 5'h00);
   wire slot_end = ch_hit && (ch_bit == wsize_m1);

   reg [FIFO_AW:0] wp_reg;
   reg [FIFO_AW:0] rp_reg;
   wire [FIFO_AW:0] level = wp_reg - rp_reg;
   wire [FIFO_AW:0] depth_c = FIFO_DEPTH[FIFO_AW:0];
   wire fifo_full = (level == depth_c);
   wire fifo_empty = (level == {(FIFO_AW+1){1'b0}});
   wire [31:0] fifo_q;
   reg [31:0] shift_reg;
   reg rd_pend_reg;

   // Bus side
   reg aw_hold_reg;
   reg w_hold_reg;
   reg [7:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   wire wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   wire cpu_push = wr_go && aw_addr_reg == `OFS_FIFO_WR && !fifo_full;
   wire rd_go = s_axi_arvalid && s_axi_arready;
   wire cpu_pop = rd_go && s_axi_araddr == `OFS_FIFO_RD && !fifo_empty && !tx_mode;
   // decimator feeds when receive and enabled
   wire mic_push = active && !tx_mode && mic_valid && mic_ready && !fifo_full;
   wire rx_push = active && !tx_mode && rise_bit && slot_end && !fifo_full;
   wire tx_pop = active && tx_mode && fall_bit && slot_start && !fifo_empty;
   wire push = (cpu_push && tx_mode) || rx_push || (mic_push && !rx_push);
   wire pop = tx_pop || cpu_pop;
   reg [31:0] push_data;
   reg [31:0] rx_word;
   always @* begin
      rx_word = {shift_reg[30:0], sda_s[1]};
      if (rx_push) begin
         push_data = rx_word;
      end else if (cpu_push && tx_mode) begin
         // Receive-mode bus writes never displace a decimator sample
         push_data = w_data_reg;
      end else begin
         push_data = mic_data;
      end
   end

   sample_fifo_mem #(
      .WIDTH(32),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_mem (
      .ref_clk(ref_clk),
      .ce(ce),
      .wr_en(push),
      .wr_addr(wp_reg[FIFO_AW-1:0]),
      .wr_data(push_data),
      .rd_addr(rp_reg[FIFO_AW-1:0]),
      .rd_data(fifo_q)
   );

   // Serial shift, MSB first
   reg tx_bit;
   always @* begin
      if (rjust) begin
         tx_bit = shift_reg[wsize_m1];
      end else begin
         tx_bit = shift_reg[31];
      end
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wp_reg <= {(FIFO_AW+1){1'b0}};
         rp_reg <= {(FIFO_AW+1){1'b0}};
         shift_reg <= 32'h0000_0000;
         rd_pend_reg <= 1'b0;
      end else if (ce) begin
         if (push) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= rp_reg + 1'b1;
         end
         rd_pend_reg <= tx_pop;
         if (rd_pend_reg) begin
            shift_reg <= fifo_q;
         end else if (tx_mode && fall_bit && ch_hit) begin
            if (rjust) begin
               shift_reg <= {shift_reg[30:0], 1'b0};
            end else begin
               shift_reg <= {shift_reg[30:0], 1'b0};
            end
         end else if (!tx_mode && rise_bit && ch_hit) begin
            shift_reg <= slot_end ? 32'h0000_0000 : rx_word;
         end
      end
   end

   // underrun and overrun events, level events
   always @* begin
      ev = 4'h0;
      ev[`ST_TX_LOW] = active && tx_mode && (level <= {1'b0, trig_reg[3:0]});
      ev[`ST_RX_HIGH] = active && !tx_mode && (level > {1'b0, trig_reg[7:4]});
      ev[`ST_UNDERRUN] = active && tx_mode && fall_bit && slot_start && fifo_empty;
      ev[`ST_OVERRUN] = active && !tx_mode && rise_bit && slot_end && fifo_full;
   end

   // Register file and bus slave
   wire [31:0] lvl_word = {{(31-FIFO_AW){1'b0}}, level};
   reg [31:0] rd_mux;
   reg rd_err;
   always @* begin
      rd_err = 1'b0;
      case (s_axi_araddr)
         `OFS_FUNC_SEL: rd_mux = {29'h0, func_reg};
         `OFS_CFG: rd_mux = cfg_reg;
         `OFS_DIV: rd_mux = {24'h0, div_reg};
         `OFS_SLOT: rd_mux = slot_reg;
         `OFS_MONO: rd_mux = {28'h0, mono_reg};
         `OFS_FIFO_TRIG: rd_mux = {24'h0, trig_reg};
         `OFS_STATUS: rd_mux = {28'h0, status_reg};
         `OFS_IRQ_MASK: rd_mux = {28'h0, mask_reg};
         `OFS_FIFO_RD: rd_mux = fifo_q;
         `OFS_FIFO_LVL: rd_mux = lvl_word;
         default: begin
            rd_mux = 32'h0000_0000;
            rd_err = 1'b1;
         end
      endcase
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         func_reg <= `FUNC_NONE;
         cfg_reg <= `CFG_RESET;
         div_reg <= `DIV_RESET;
         slot_reg <= 32'h0302_0100;
         mono_reg <= 4'h0;
         trig_reg <= `TRIG_RESET;
         status_reg <= 4'h0;
         mask_reg <= 4'h0;
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
      end else if (ce) begin
         s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            case (aw_addr_reg)
               `OFS_FUNC_SEL: func_reg <= w_data_reg[2:0];
               `OFS_CFG: if (func_reg == `FUNC_I2S) cfg_reg <= w_data_reg;
               `OFS_DIV: if (func_reg == `FUNC_I2S) div_reg <= w_data_reg[7:0];
               `OFS_SLOT: if (func_reg == `FUNC_I2S) slot_reg <= w_data_reg;
               `OFS_MONO: if (func_reg == `FUNC_I2S) mono_reg <= w_data_reg[3:0];
               `OFS_FIFO_TRIG: trig_reg <= w_data_reg[7:0];
               `OFS_IRQ_MASK: mask_reg <= w_data_reg[3:0];
               `OFS_FIFO_WR: mask_reg <= mask_reg;
               default: s_axi_bresp <= `RESP_SLVERR;
            endcase
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
         end
         // Set wins over read-to-clear
         if (rd_go && s_axi_araddr == `OFS_STATUS) begin
            status_reg <= ev;
         end else begin
            status_reg <= status_reg | ev;
         end
      end
   end

   // Pin and request outputs, all registered
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sck_out <= 1'b0;
         sck_oe <= 1'b0;
         ws_out <= 1'b0;
         ws_oe <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         mic_ready <= 1'b0;
         dma_tx_req <= 1'b0;
         dma_rx_req <= 1'b0;
         irq <= 1'b0;
      end else if (ce) begin
         sck_oe <= master;
         ws_oe <= master;
         sck_out <= msck_reg ^ cfg_reg[`CFG_SCK_INV];
         // select polarity; TDM uses one-bit pulse
         if (cfg_reg[`CFG_TDM]) begin
            ws_out <= (bitpos_reg == 8'h00) ^ cfg_reg[`CFG_WS_INV];
         end else begin
            ws_out <= (bitpos_reg > {1'b0, frame_m1[7:1]}) ^ cfg_reg[`CFG_WS_INV];
         end
         // one data line, driven only when sending in a slot
         sda_oe <= active && tx_mode && ch_hit;
         sda_out <= tx_bit;
         mic_ready <= active && !tx_mode && !fifo_full;
         dma_tx_req <= ev[`ST_TX_LOW];
         dma_rx_req <= ev[`ST_RX_HIGH];
         irq <= |(status_reg & mask_reg);
      end
   end
endmodule // i2s_serial_port
`default_nettype wire

// [tb/i2s_serial_port_properties.sv]
// Port-level assertions for the serial audio port
`timescale 1ns/1ps
`default_nettype none
module i2s_port_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Bus handshakes
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Link pins
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic ws_oe,
   input wire logic sda_oe,
   // Stream, requests, interrupt
   input wire logic mic_ready,
   input wire logic dma_tx_req,
   input wire logic dma_rx_req,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   property p_quiet_after_reset;
      $fell(rst) |-> !irq && !sck_oe && !sda_oe && !s_axi_bvalid;
   endproperty
   a_quiet_after_reset: assert property (p_quiet_after_reset) else $error("output active after reset");
   property p_bvalid_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");
   property p_rvalid_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
   endproperty
   a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped early");
   property p_aw_pulse;
      s_axi_awready |=> !s_axi_awready;
   endproperty
   a_aw_pulse: assert property (p_aw_pulse) else $error("address ready held too long");
   property p_read_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read data late");
   property p_pair0_master;
      sck_oe == ws_oe;
   endproperty
   a_pair0_master: assert property (p_pair0_master) else $error("clock and select drive differ");
   property p_sck_half;
      $changed(sck_out) && sck_oe |=> ($stable(sck_out) || !sck_oe)[*4];
   endproperty
   a_sck_half: assert property (p_sck_half) else $error("bit clock half period short");
   property p_dma_dir;
      !(dma_tx_req && dma_rx_req);
   endproperty
   a_dma_dir: assert property (p_dma_dir) else $error("both request lines high");
   property p_mic_rx_only;
      sda_oe |-> !mic_ready;
   endproperty
   a_mic_rx_only: assert property (p_mic_rx_only) else $error("stream accepted while sending");
endmodule // i2s_port_checker

bind i2s_serial_port i2s_port_checker u_chk (.ref_clk(ref_clk), .rst(rst),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .sck_out(sck_out), .sck_oe(sck_oe), .ws_oe(ws_oe),
   .sda_oe(sda_oe), .mic_ready(mic_ready), .dma_tx_req(dma_tx_req),
   .dma_rx_req(dma_rx_req), .irq(irq));
`default_nettype wire

// [tb/i2s_codec_model.sv]
// Far-side audio codec: bit clock source in slave tests, bit sink always
`timescale 1ns/1ps
`default_nettype none
module i2s_codec_model (
   // Control
   input wire logic drive,
   // Resolved lines
   input wire logic sck_line,
   input wire logic sda_line,
   // Driven lines
   output logic m_sck,
   output logic m_ws,
   output logic m_sda
);
   bit bits[$];
   int n;
   // no master clock, bit clock runs whenever drive is high, select toggles every 16 bits
   initial begin
      m_sck = 1'b0;
      m_ws = 1'b0;
      n = 0;
      #37;
      forever begin
         #400;
         m_sck = drive ? ~m_sck : 1'b0;
         if (drive && !m_sck) begin
            n++;
            if (n % 16 == 0) m_ws = ~m_ws;
         end
      end
   end
   // Data keeps changing so a stale bit never passes
   initial begin
      m_sda = 1'b0;
      forever #130 m_sda = ~m_sda;
   end
   // one data line, sampled on rising clock
   always @(posedge sck_line) bits.push_back(sda_line);
endmodule // i2s_codec_model
`default_nettype wire

// [tb/multi_pair_i2s_serial_port_tb.sv]
// Self-checking bench for the serial audio port
`timescale 1ns/1ps
`default_nettype none
`include "i2s_port_defines.vh"
module multi_pair_i2s_serial_port_tb;
   localparam logic [31:0] RX_CFG = 32'h01F0_F101;
   localparam logic [31:0] TX_CFG = 32'h01F0_F107;
   logic ref_clk = 1'b0, rst = 1'b1, drive = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, mic_data = 32'h0, rd, v;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, mic_valid = 1'b0;
   logic [1:0] resp;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire sck_out, sck_oe, ws_out, ws_oe, sda_out, sda_oe, mic_ready;
   wire dma_tx_req, dma_rx_req, irq, m_sck, m_ws, m_sda;
   wire sck_w = sck_oe ? sck_out : m_sck;
   wire ws_w = ws_oe ? ws_out : m_ws;
   wire sda_w = sda_oe ? sda_out : m_sda;
   int bad_count = 0, n_tests = 0, cyc = 0, n;
   logic [31:0] q[$];

   always #50 ref_clk = ~ref_clk;

   i2s_serial_port u_dut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sck_in(sck_w),
      .sck_out(sck_out), .sck_oe(sck_oe), .ws_in(ws_w), .ws_out(ws_out), .ws_oe(ws_oe),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .mic_data(mic_data),
      .mic_valid(mic_valid), .mic_ready(mic_ready), .dma_tx_req(dma_tx_req),
      .dma_rx_req(dma_rx_req), .irq(irq));
   i2s_codec_model u_model (.drive(drive), .sck_line(sck_w), .sda_line(sda_w),
      .m_sck(m_sck), .m_ws(m_ws), .m_sda(m_sda));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
      if (n >= 100) bad_count++;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      if (n >= 100) bad_count++;
   endtask
   function automatic logic found(input logic [15:0] w);
      logic [15:0] sh = 16'h0;
      foreach (u_model.bits[i]) begin
         sh = {sh[14:0], u_model.bits[i]};
         if (i >= 15 && sh == w) return 1'b1;
      end
      return 1'b0;
   endfunction
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   initial begin
      void'($urandom(36));
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      rdr(`OFS_CFG); chk(rd, `CFG_RESET);
      rdr(`OFS_DIV); chk(rd, {24'h0, `DIV_RESET});
      rdr(`OFS_FIFO_TRIG); chk(rd, {24'h0, `TRIG_RESET});
      rdr(8'h40); chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
      // Configuration held off until the function is chosen
      wr(`OFS_CFG, RX_CFG); rdr(`OFS_CFG); chk(rd, `CFG_RESET);
      wr(`OFS_FUNC_SEL, {29'h0, `FUNC_I2S});
      chk({30'h0, resp}, {30'h0, `RESP_OKAY});
      wr(`OFS_CFG, RX_CFG); rdr(`OFS_CFG); chk(rd, RX_CFG);
      // Decimator stream fills the FIFO
      for (int i = 0; i < 8; i++) begin
         v = $urandom;
         q.push_back(v);
         mic_data <= v;
         mic_valid <= 1'b1;
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (mic_ready !== 1'b1 && n < 50);
      end
      mic_valid <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk(mic_ready, 1'b0);
      chk(dma_rx_req, 1'b1);
      rdr(`OFS_FIFO_LVL); chk(rd, 32'h8);
      for (int i = 0; i < 8; i++) begin
         rdr(`OFS_FIFO_RD); chk(rd, q.pop_front());
      end
      repeat (3) @(posedge ref_clk);
      chk(dma_rx_req, 1'b0);
      // Slave receive from the codec's clock until overrun
      drive = 1'b1;
      repeat (3200) @(posedge ref_clk);
      chk(sck_oe, 1'b0);
      drive = 1'b0;
      rdr(`OFS_FIFO_LVL); chk(rd, 32'h8);
      rdr(`OFS_STATUS); chk(rd[`ST_OVERRUN], 1'b1);
      repeat (8) rdr(`OFS_FIFO_RD);
      // Master transmit: underrun masked, then unmasked
      wr(`OFS_IRQ_MASK, 32'h0);
      wr(`OFS_CFG, TX_CFG);
      repeat (800) @(posedge ref_clk);
      chk(irq, 1'b0);
      chk(sck_oe, 1'b1);
      chk(ws_oe, 1'b1);
      chk(dma_tx_req, 1'b1);
      wr(`OFS_IRQ_MASK, 32'h4);
      repeat (3) @(posedge ref_clk);
      chk(irq, 1'b1);
      u_model.bits.delete();
      for (int i = 0; i < 4; i++) begin
         // Left-justified: sample sits in the upper half of the word
         v = {16'($urandom), 16'h0};
         q.push_back(v);
         wr(`OFS_FIFO_WR, v);
      end
      repeat (2000) @(posedge ref_clk);
      wr(`OFS_CFG, TX_CFG & 32'hFFFF_FFFE);
      rdr(`OFS_STATUS); chk(rd[`ST_UNDERRUN], 1'b1);
      repeat (3) @(posedge ref_clk);
      chk(irq, 1'b0);
      while (q.size() > 0) begin
         v = q.pop_front();
         chk(found(v[31:16]), 1'b1);
      end
      // Right-justified: sample sits in the lower half of the word
      wr(`OFS_CFG, TX_CFG | 32'h8);
      u_model.bits.delete();
      v = {16'h0, 16'($urandom)};
      wr(`OFS_FIFO_WR, v);
      repeat (700) @(posedge ref_clk);
      chk(found(v[15:0]), 1'b1);
      end_of_test();
   end
endmodule // multi_pair_i2s_serial_port_tb
`default_nettype wire
